// file: trace_pkg.sv
// constants, types and register map of the trace capture buffer
//
// Contract
// R1: capture starts by itself whenever emulation is started, no arming needed.
// R2: capture stops on halt request, breakpoint, capture-halt command, or full after trigger.
// R3: a halt request stops both capture and emulation.
// R4: after a trigger, capture stops once the post-trigger frame count is stored.
// R5: capture-halt command stops recording, emulation runs on, stopped flag is set.
// R6: capture-resume command restarts recording while emulation still runs.
// R7: frames are indexed from trigger: negative before, zero at, positive after.
// R8: each frame holds cycle type (fetch, write, read), address and data.
// R9: each frame holds interrupt level, zero for main program, one for level one.
// R10: each frame holds the full state of port one and port three.
// R11: each frame holds both sync probes and both extra probes.
// R12: frames stored after the trigger are counted and readable while running.
// R13: frames stored before the trigger are counted and readable.
// R14: completed trace loops are counted and readable.
// R15: five flags: qualifier a, qualifier b, triggered, loop done or stopped, done.
// R16: the buffer keeps the most recent 16K frames, 4K in the small build.
// R17: pre/post split is adjustable and defaults to mid buffer.
// R18: loop count setting picks which trigger pass starts the real capture.
// R19: buffer is written circularly, oldest frame overwritten first.
package trace_pkg;

	// ----------------------------------------------------------------
	// buffer size
	// ----------------------------------------------------------------
	localparam int unsigned DEF_DEPTH_LOG2   = 14;
	localparam int unsigned SMALL_DEPTH_LOG2 = 12;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_TRIG_POS  = 8'h04;
	localparam logic [7:0] OFS_LOOP_SET  = 8'h08;
	localparam logic [7:0] OFS_STATUS    = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;
	localparam logic [7:0] OFS_POST_CNT  = 8'h18;
	localparam logic [7:0] OFS_PRE_CNT   = 8'h1c;
	localparam logic [7:0] OFS_LOOP_CNT  = 8'h20;
	localparam logic [7:0] OFS_RD_INDEX  = 8'h24;
	localparam logic [7:0] OFS_FRAME_LO  = 8'h28;
	localparam logic [7:0] OFS_FRAME_HI  = 8'h2c;

	// ----------------------------------------------------------------
	// control bits (write one, self clearing)
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_GO     = 0;
	localparam int unsigned CTRL_HALT   = 1;
	localparam int unsigned CTRL_END    = 2;
	localparam int unsigned CTRL_RESUME = 3;

	// ----------------------------------------------------------------
	// status / interrupt bits
	// ----------------------------------------------------------------
	localparam int unsigned NUM_FLAGS = 5;
	localparam int unsigned ST_QUAL_A = 0;
	localparam int unsigned ST_QUAL_B = 1;
	localparam int unsigned ST_TRIG   = 2;
	localparam int unsigned ST_STOP   = 3;
	localparam int unsigned ST_DONE   = 4;
	localparam int unsigned ST_RUN    = 5;
	localparam int unsigned ST_EMU    = 6;

	localparam logic [15:0] LOOP_SET_RST = 16'h0000;
	localparam logic [4:0]  IRQ_MASK_RST = 5'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CYC_NONE  = 2'b00,
		CYC_FETCH = 2'b01,
		CYC_WRITE = 2'b10,
		CYC_READ  = 2'b11
	} cycle_type_field_t;

	typedef enum logic [1:0] {
		CAP_IDLE = 2'b00,
		CAP_PRE  = 2'b01,
		CAP_POST = 2'b10,
		CAP_DONE = 2'b11
	} cap_state_t;

	typedef struct packed {
		cycle_type_field_t cycle_type_field;
		logic [15:0]       addr;
		logic [7:0]        data;
		logic [2:0]        int_level;
		logic [7:0]        port_one_state;
		logic [7:0]        port_three_state;
		logic              sync_probe_one;
		logic              sync_probe_zero;
		logic              extra_probe_one;
		logic              extra_probe_zero;
	} frame_t;

	typedef struct packed {
		logic   valid;
		frame_t frame;
	} target_bus_t;

	localparam int unsigned FRAME_W = $bits(frame_t);

endpackage : trace_pkg

// file: trace_ram.sv
// simple dual port frame memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module trace_ram #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned AW    = 4
) (
	input  wire logic             clk,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		rdata <= mem[raddr];
	end

endmodule : trace_ram
`default_nettype wire

// file: trace_capture_buffer.sv
// trace capture core: target bus sampling, trigger logic, ahb-lite registers
`timescale 1ns/100ps
`default_nettype none
module trace_capture_buffer #(
	parameter int unsigned DEPTH_LOG2 = trace_pkg::DEF_DEPTH_LOG2
) (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	input  wire trace_pkg::target_bus_t bus_in,
	input  wire logic                breakpoint_hit,
	input  wire logic                trigger_event,
	input  wire logic                qualifier_a_match,
	input  wire logic                qualifier_b_match,
	output logic                     emulation_run,
	output logic                     capture_active,
	output logic                     irq
);
	import trace_pkg::*;

	localparam int unsigned DEPTH = 1 << DEPTH_LOG2;
	localparam logic [15:0] TRIG_POS_RST = 16'(DEPTH / 2);
	localparam logic [15:0] CNT_MAX      = 16'(DEPTH);
	localparam logic [DEPTH_LOG2-1:0] PTR_ONE = {{(DEPTH_LOG2-1){1'b0}}, 1'b1};

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	target_bus_t bus_s1_r;
	target_bus_t bus_s2_r;
	logic        valid_s3_r;
	logic [3:0]  misc_s1_r;
	logic [3:0]  misc_s2_r;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bus_s1_r   <= '0;
			bus_s2_r   <= '0;
			valid_s3_r <= 1'b0;
			misc_s1_r  <= 4'h0;
			misc_s2_r  <= 4'h0;
		end
		else
		begin
			bus_s1_r   <= bus_in;
			bus_s2_r   <= bus_s1_r;
			valid_s3_r <= bus_s2_r.valid;
			misc_s1_r  <= {breakpoint_hit, trigger_event, qualifier_b_match, qualifier_a_match};
			misc_s2_r  <= misc_s1_r;
		end
	end

	logic frame_stb;
	logic bp_s;
	logic trig_s;
	assign frame_stb = bus_s2_r.valid & ~valid_s3_r;
	assign bp_s      = misc_s2_r[3];
	assign trig_s    = misc_s2_r[2];

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	logic       wr_pend_r;
	logic [7:0] wr_addr_r;
	logic       addr_ok;
	logic       rd_take;
	assign addr_ok   = hsel & hready & htrans[1] & (haddr[31:8] == 24'h000000);
	assign rd_take   = addr_ok & ~hwrite;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_r <= addr_ok & hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	logic wr_ctrl;
	logic cmd_go;
	logic cmd_halt;
	logic cmd_end;
	logic cmd_resume;
	assign wr_ctrl    = wr_pend_r & hit(wr_addr_r, OFS_CTRL);
	assign cmd_go     = wr_ctrl & hwdata[CTRL_GO];
	assign cmd_halt   = wr_ctrl & hwdata[CTRL_HALT];
	assign cmd_end    = wr_ctrl & hwdata[CTRL_END];
	assign cmd_resume = wr_ctrl & hwdata[CTRL_RESUME];

	logic [15:0]     trig_pos_r;
	logic [15:0]     loop_set_r;
	logic [4:0]      irq_mask_r;
	logic [15:0]     rd_index_r;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			trig_pos_r <= TRIG_POS_RST;
			loop_set_r <= LOOP_SET_RST;
			irq_mask_r <= IRQ_MASK_RST;
			rd_index_r <= 16'h0000;
		end
		else if (wr_pend_r)
		begin
			if (hit(wr_addr_r, OFS_TRIG_POS))
				trig_pos_r <= hwdata[15:0]; // R17
			if (hit(wr_addr_r, OFS_LOOP_SET))
				loop_set_r <= hwdata[15:0]; // R18
			if (hit(wr_addr_r, OFS_IRQ_MASK))
				irq_mask_r <= hwdata[4:0];
			if (hit(wr_addr_r, OFS_RD_INDEX))
				rd_index_r <= hwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// emulation and capture control
	// ----------------------------------------------------------------
	cap_state_t            state_r;
	logic                  emu_r;
	logic [DEPTH_LOG2-1:0] wr_ptr_r;
	logic [DEPTH_LOG2-1:0] trig_addr_r;
	logic [15:0]           pre_cnt_r;
	logic [15:0]           post_cnt_r;
	logic [15:0]           loop_cnt_r;
	logic [4:0]            flags_r;

	logic active;
	logic stop_now;
	logic frame_we;
	logic trig_hit;
	logic post_full;
	assign active    = (state_r == CAP_PRE) | (state_r == CAP_POST);
	assign stop_now  = active & (cmd_halt | bp_s | cmd_end); // R2
	assign frame_we  = active & frame_stb & ~stop_now & ~cmd_go;
	assign trig_hit  = (state_r == CAP_PRE) & frame_we & trig_s;
	assign post_full = ((post_cnt_r + 16'h0001) >= trig_pos_r);

	logic restart;
	assign restart = cmd_go | (cmd_resume & emu_r & ~active & ~cmd_halt & ~bp_s);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			emu_r <= 1'b0;
		end
		else if (cmd_halt | bp_s)
		begin
			emu_r <= 1'b0; // R3
		end
		else if (cmd_go)
		begin
			emu_r <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= CAP_IDLE;
		end
		else if (stop_now)
		begin
			state_r <= CAP_IDLE; // R3 R5
		end
		else if (restart & ~cmd_halt & ~bp_s)
		begin
			state_r <= CAP_PRE; // R1 R6
		end
		else
		begin
			case (state_r)
				CAP_PRE:
					if (trig_hit && loop_cnt_r == loop_set_r)
						state_r <= (trig_pos_r == 16'h0000) ? CAP_DONE : CAP_POST; // R18
				CAP_POST:
					if (frame_we && post_full)
						state_r <= CAP_DONE; // R4
				CAP_IDLE, CAP_DONE:
					state_r <= state_r;
				default:
					state_r <= CAP_IDLE;
			endcase
		end
	end

	// circular write pointer and trigger position
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_ptr_r    <= '0;
			trig_addr_r <= '0;
		end
		else
		begin
			if (frame_we)
				wr_ptr_r <= wr_ptr_r + PTR_ONE; // R19 R16
			if (trig_hit && loop_cnt_r == loop_set_r)
				trig_addr_r <= wr_ptr_r; // R7
		end
	end

	// counters; pre count saturates at buffer size since older frames are gone
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pre_cnt_r  <= 16'h0000;
			post_cnt_r <= 16'h0000;
			loop_cnt_r <= 16'h0000;
		end
		else if (restart)
		begin
			pre_cnt_r  <= 16'h0000;
			post_cnt_r <= 16'h0000;
			loop_cnt_r <= 16'h0000;
		end
		else
		begin
			if (frame_we && state_r == CAP_PRE && !(trig_s && loop_cnt_r == loop_set_r)
				&& pre_cnt_r != CNT_MAX)
				pre_cnt_r <= pre_cnt_r + 16'h0001; // R13
			if (frame_we && state_r == CAP_POST)
				post_cnt_r <= post_cnt_r + 16'h0001; // R12
			if (trig_hit && loop_cnt_r != loop_set_r)
				loop_cnt_r <= loop_cnt_r + 16'h0001; // R14 R18
		end
	end

	// live flags, cleared by a fresh start
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			flags_r <= 5'h00;
		end
		else if (restart & ~cmd_halt & ~bp_s)
		begin
			flags_r <= 5'h00;
		end
		else
		begin
			if (active & misc_s2_r[0])
				flags_r[ST_QUAL_A] <= 1'b1; // R15
			if (active & misc_s2_r[1])
				flags_r[ST_QUAL_B] <= 1'b1; // R15
			if (trig_hit && loop_cnt_r == loop_set_r)
			begin
				flags_r[ST_TRIG] <= 1'b1; // R15
				flags_r[ST_STOP] <= 1'b1;
			end
			if (stop_now)
				flags_r[ST_STOP] <= 1'b1; // R5
			if (state_r == CAP_DONE)
				flags_r[ST_DONE] <= 1'b1; // R15
		end
	end

	// ----------------------------------------------------------------
	// interrupt status: set on a flag's rise, read clears, set wins
	// ----------------------------------------------------------------
	logic [4:0] flags_d_r;
	logic [4:0] irq_stat_r;
	logic       irq_rd;
	assign irq_rd = rd_take & hit(haddr[7:0], OFS_IRQ_STAT);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			flags_d_r  <= 5'h00;
			irq_stat_r <= 5'h00;
		end
		else
		begin
			flags_d_r  <= flags_r;
			irq_stat_r <= (irq_rd ? 5'h00 : irq_stat_r) | (flags_r & ~flags_d_r);
		end
	end

	assign irq            = |(irq_stat_r & irq_mask_r);
	assign emulation_run  = emu_r;
	assign capture_active = active;

	// ----------------------------------------------------------------
	// frame memory and trigger-relative read back
	// ----------------------------------------------------------------
	logic [DEPTH_LOG2-1:0] ref_addr;
	logic [DEPTH_LOG2-1:0] rd_addr;
	frame_t                rd_frame;
	assign ref_addr = flags_r[ST_TRIG] ? trig_addr_r : wr_ptr_r - PTR_ONE;
	assign rd_addr  = ref_addr + rd_index_r[DEPTH_LOG2-1:0]; // R7

	trace_ram #(
		.WIDTH (FRAME_W),
		.AW    (DEPTH_LOG2)
	) u_ram (
		.clk   (hclk),
		.we    (frame_we),
		.waddr (wr_ptr_r),
		.wdata (bus_s2_r.frame), // R8 R9 R10 R11
		.raddr (rd_addr),
		.rdata (rd_frame)
	);

	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
			OFS_TRIG_POS: rd_mux = {16'h0000, trig_pos_r};
			OFS_LOOP_SET: rd_mux = {16'h0000, loop_set_r};
			OFS_STATUS:   rd_mux = {25'h0000000, emu_r, active, flags_r};
			OFS_IRQ_STAT: rd_mux = {27'h0000000, irq_stat_r};
			OFS_IRQ_MASK: rd_mux = {27'h0000000, irq_mask_r};
			OFS_POST_CNT: rd_mux = {16'h0000, post_cnt_r};
			OFS_PRE_CNT:  rd_mux = {16'h0000, pre_cnt_r};
			OFS_LOOP_CNT: rd_mux = {16'h0000, loop_cnt_r};
			OFS_RD_INDEX: rd_mux = {16'h0000, rd_index_r};
			OFS_FRAME_LO: rd_mux = {3'h0, rd_frame.cycle_type_field, rd_frame.int_level,
				rd_frame.data, rd_frame.addr};
			OFS_FRAME_HI: rd_mux = {12'h000, rd_frame.sync_probe_one, rd_frame.sync_probe_zero,
				rd_frame.extra_probe_one, rd_frame.extra_probe_zero,
				rd_frame.port_three_state, rd_frame.port_one_state};
			default:      rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h00000000;
		end
		else if (rd_take)
		begin
			hrdata <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_stopping;
		active && (cmd_halt || bp_s || cmd_end);
	endsequence

	sequence s_end_only;
		active && cmd_end && !cmd_halt && !bp_s && !cmd_go;
	endsequence

	property p_go_starts;
		@(posedge hclk) disable iff (!hresetn)
		cmd_go && !cmd_halt && !bp_s && !(active && cmd_end) |=> state_r == CAP_PRE && emu_r;
	endproperty
	a_go_starts: assert property (p_go_starts) else $error("capture not started by go"); // R1

	property p_stop_sources;
		@(posedge hclk) disable iff (!hresetn)
		s_stopping |=> state_r == CAP_IDLE && !capture_active;
	endproperty
	a_stop_sources: assert property (p_stop_sources) else $error("capture kept running"); // R2

	property p_halt_both;
		@(posedge hclk) disable iff (!hresetn)
		cmd_halt |=> !emulation_run && !capture_active;
	endproperty
	a_halt_both: assert property (p_halt_both) else $error("halt left something running"); // R3

	property p_post_done;
		@(posedge hclk) disable iff (!hresetn)
		state_r == CAP_POST && frame_we && post_full
		|=> state_r == CAP_DONE && post_cnt_r == trig_pos_r ##1 flags_r[ST_DONE];
	endproperty
	a_post_done: assert property (p_post_done) else $error("post trigger stop wrong"); // R4

	property p_end_keeps_emu;
		@(posedge hclk) disable iff (!hresetn)
		s_end_only |=> !capture_active && emulation_run && flags_r[ST_STOP];
	endproperty
	a_end_keeps_emu: assert property (p_end_keeps_emu) else $error("capture end wrong"); // R5

	property p_resume;
		@(posedge hclk) disable iff (!hresetn)
		s_end_only ##[1:300] (cmd_resume && emu_r && !active && !cmd_halt && !bp_s)
		|=> state_r == CAP_PRE;
	endproperty
	a_resume: assert property (p_resume) else $error("resume did not restart"); // R6

	property p_wrap;
		@(posedge hclk) disable iff (!hresetn)
		frame_we |=> wr_ptr_r == $past(wr_ptr_r) + PTR_ONE;
	endproperty
	a_wrap: assert property (p_wrap) else $error("write pointer not advancing"); // R19

	property p_loop_skip;
		@(posedge hclk) disable iff (!hresetn)
		trig_hit && loop_cnt_r != loop_set_r && !restart
		|=> state_r == CAP_PRE && loop_cnt_r == $past(loop_cnt_r) + 16'h0001;
	endproperty
	a_loop_skip: assert property (p_loop_skip) else $error("early trigger pass taken"); // R18

	property p_irq_sticky;
		@(posedge hclk) disable iff (!hresetn)
		irq_stat_r[ST_TRIG] && !irq_rd |=> irq_stat_r[ST_TRIG];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("status bit lost"); // R15

endmodule : trace_capture_buffer
`default_nettype wire

// file: target_model.sv
// behavioural model of the emulated target bus feeding frames
`timescale 1ns/100ps
`default_nettype none
module target_model
(
	input  wire logic            hclk,
	output var  trace_pkg::target_bus_t bus_in,
	output var  logic            trigger_event
);
	import trace_pkg::*;

	initial
	begin
		bus_in        = '0;
		trigger_event = 1'b0;
	end

	// ------------------------------------------------------------
	// one bus cycle: fields settle, valid rises, fields held, gap
	// ------------------------------------------------------------
	// fields are inverted after the hold so a stale frame cannot pass
	task automatic send(input frame_t f, input logic trig, input int gap);
		bus_in.frame <= f;
		repeat (2) @(posedge hclk);
		bus_in.valid  <= 1'b1;
		trigger_event <= trig;
		repeat (4) @(posedge hclk);
		bus_in.valid  <= 1'b0;
		trigger_event <= 1'b0;
		repeat (2) @(posedge hclk);
		bus_in.frame <= ~f;
		repeat (2 + gap) @(posedge hclk);
	endtask : send
endmodule : target_model
`default_nettype wire

// file: testbench.sv
// self-checking testbench of the trace capture buffer
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import trace_pkg::*;

	localparam int DL = 4;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	target_bus_t bus_in;
	logic        trigger_event;
	logic        breakpoint_hit = 1'b0;
	logic        qual_a = 1'b0;
	logic        qual_b = 1'b0;
	logic        emulation_run;
	logic        capture_active;
	logic        irq;
	int          errors = 0;
	int          comparisons = 0;
	logic [31:0] d;

	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;

	trace_capture_buffer #(.DEPTH_LOG2(DL)) u_trace_capture_buffer (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .bus_in(bus_in), .breakpoint_hit(breakpoint_hit),
		.trigger_event(trigger_event), .qualifier_a_match(qual_a), .qualifier_b_match(qual_b),
		.emulation_run(emulation_run), .capture_active(capture_active), .irq(irq)
	);

	target_model u_target_model (.hclk(hclk), .bus_in(bus_in), .trigger_event(trigger_event));

	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// ------------------------------------------------------------
	// ahb-lite single word transfers
	// ------------------------------------------------------------
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && n < 32)
		begin
			n++;
			@(posedge hclk);
		end
		if (n >= 32)
		begin
			errors++;
			report_and_stop();
		end
	endtask : wait_ready

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] x;
		ahb(1'b1, a, v, x);
	endtask : wr

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		chk(nm, x, exp);
	endtask : rd_chk

	task automatic settle(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : settle

	function automatic frame_t mk(input int i);
		frame_t f;
		f.cycle_type_field = cycle_type_field_t'(2'(i % 3 + 1));
		f.addr             = 16'h4000 + 16'(i);
		f.data             = 8'(i * 7 + 3);
		f.int_level        = 3'(i);
		f.port_one_state   = 8'hff - 8'(i);
		f.port_three_state = 8'(i * 5);
		{f.sync_probe_one, f.sync_probe_zero, f.extra_probe_one, f.extra_probe_zero} = 4'(i);
		return f;
	endfunction : mk

	task automatic chk_frame(input int idx, input int k);
		frame_t f;
		f = mk(k);
		wr(OFS_RD_INDEX, 32'(idx));
		settle(2);
		rd_chk("frame_lo", OFS_FRAME_LO, {3'h0, f.cycle_type_field, f.int_level, f.data, f.addr});
		rd_chk("frame_hi", OFS_FRAME_HI, {12'h0, f.sync_probe_one, f.sync_probe_zero,
			f.extra_probe_one, f.extra_probe_zero, f.port_three_state, f.port_one_state});
	endtask : chk_frame

	function automatic logic [31:0] bitv(input int unsigned b);
		return 32'h1 << b;
	endfunction : bitv

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		settle(1);
		rd_chk("trig_pos", OFS_TRIG_POS, 32'h1 << (DL - 1));
		rd_chk("loop_set", OFS_LOOP_SET, 32'h0);
		rd_chk("status", OFS_STATUS, 32'h0);
		chk("resp", {30'h0, hreadyout, hresp}, 32'h2);
		wr(8'h30, 32'hffff_ffff);
		rd_chk("unmapped", 8'h30, 32'h0);
		wr(OFS_TRIG_POS, 32'h2);
		wr(OFS_CTRL, bitv(CTRL_GO));
		settle(1);
		chk("emu", {31'h0, emulation_run}, 32'h1);
		chk("cap", {31'h0, capture_active}, 32'h1);
		qual_a <= 1'b1;
		qual_b <= 1'b1;
		settle(3);
		qual_a <= 1'b0;
		qual_b <= 1'b0;
		for (int k = 0; k < 6; k++)
			u_target_model.send(mk(k), k == 3, (k == 4) ? 5 : 0);
		rd_chk("pre_cnt", OFS_PRE_CNT, 32'h3);
		rd_chk("post_cnt", OFS_POST_CNT, 32'h2);
		chk("cap_done", {31'h0, capture_active}, 32'h0);
		rd_chk("status", OFS_STATUS, 32'h5f);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h1f);
		settle(1);
		chk("irq_on", {31'h0, irq}, 32'h1);
		rd_chk("irq_stat", OFS_IRQ_STAT, 32'h1f);
		settle(1);
		chk("irq_off", {31'h0, irq}, 32'h0);
		rd_chk("irq_stat_clr", OFS_IRQ_STAT, 32'h0);
		for (int i = -3; i < 3; i++)
			chk_frame(i, i + 3);
		wr(OFS_CTRL, bitv(CTRL_RESUME));
		wr(OFS_CTRL, bitv(CTRL_END));
		settle(1);
		chk("end_cap", {31'h0, capture_active}, 32'h0);
		chk("end_emu", {31'h0, emulation_run}, 32'h1);
		ahb(1'b0, OFS_STATUS, 32'h0, d);
		chk("stop_flag", d & bitv(ST_STOP), bitv(ST_STOP));
		u_target_model.send(mk(40), 1'b0, 0);
		rd_chk("pre_dropped", OFS_PRE_CNT, 32'h0);
		wr(OFS_LOOP_SET, 32'h1);
		wr(OFS_CTRL, bitv(CTRL_RESUME));
		settle(1);
		chk("resume_cap", {31'h0, capture_active}, 32'h1);
		u_target_model.send(mk(41), 1'b1, 0);
		rd_chk("loop_cnt", OFS_LOOP_CNT, 32'h1);
		ahb(1'b0, OFS_STATUS, 32'h0, d);
		chk("pass_skipped", d & bitv(ST_TRIG), 32'h0);
		u_target_model.send(mk(42), 1'b1, 0);
		ahb(1'b0, OFS_STATUS, 32'h0, d);
		chk("pass_taken", d & bitv(ST_TRIG), bitv(ST_TRIG));
		wr(OFS_CTRL, bitv(CTRL_HALT));
		settle(1);
		chk("halt_emu", {31'h0, emulation_run}, 32'h0);
		chk("halt_cap", {31'h0, capture_active}, 32'h0);
		wr(OFS_LOOP_SET, 32'h0);
		wr(OFS_TRIG_POS, 32'h0);
		wr(OFS_CTRL, bitv(CTRL_GO));
		breakpoint_hit <= 1'b1;
		for (int n = 0; n < 20 && emulation_run !== 1'b0; n++)
			settle(1);
		if (emulation_run !== 1'b0)
		begin
			errors++;
			report_and_stop();
		end
		chk("bp_emu", {31'h0, emulation_run}, 32'h0);
		chk("bp_cap", {31'h0, capture_active}, 32'h0);
		breakpoint_hit <= 1'b0;
		settle(2);
		wr(OFS_CTRL, bitv(CTRL_GO));
		for (int k = 0; k < 20; k++)
			u_target_model.send(mk(k + 10), 1'b0, 0);
		u_target_model.send(mk(30), 1'b1, 0);
		chk("wrap_done", {31'h0, capture_active}, 32'h0);
		rd_chk("pre_sat", OFS_PRE_CNT, 32'h1 << DL);
		chk_frame(0, 30);
		chk_frame(-1, 29);
		chk_frame(-15, 15);
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
